/* File: src/video_pixel_output_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "pixel_port_defs.vh"

module pixel_fifo #(
  parameter W  = 19,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          sys_clk,
  input  wire          sys_rst,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  output wire [AW:0]   level
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  integer i;

  assign in_ready  = (count < D);
  assign out_valid = (count != 0);
  assign out_data  = mem[rd_ptr];
  assign level     = count;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      for (i = 0; i < D; i = i + 1)
        mem[i] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// Behaviour
// - The double-rate clock follows the selected reference and the single-rate clock is half of it.
// - Either the NTSC or the PAL reference input can be chosen to make the output clocks.
// - In byte mode each pixel goes out as chroma on one clock and luma on the next.
// - The port carries YCrCb 4:2:2 over a path of 8 or 16 bits.
// - Blanking pixels are sent as well as active ones, paced by the rate that suits the width.
// - Optional control codes outside the legal ranges mark active video, line start and field start.
// - Horizontal and vertical ratios are set independently, down to one sixteenth.
// - Horizontal scaling uses a six-tap filter and vertical scaling a five-tap line store filter.
// - With the vertical filter off, vertical reduction only drops whole lines.
// - Programmed windows crop the active lines and the active pixels per line.
// - Whole fields or frames are dropped at a programmable regular interval.
// - The input selector picks one of four sources, with S-Video chroma bypassing it.
module video_pixel_output_port (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        ntsc_xtal,
  input  wire        pal_xtal,
  input  wire        pal_select,
  input  wire [15:0] src0,
  input  wire [15:0] src1,
  input  wire [15:0] src2,
  input  wire [15:0] src3,
  input  wire [7:0]  svideo_chroma,
  input  wire        svideo_mode,
  input  wire [1:0]  input_select,
  input  wire        in_valid,
  input  wire        in_line_start,
  input  wire        in_field_start,
  input  wire        in_field,
  output reg         src_ready,
  input  wire [15:0] hscale_step,
  input  wire [15:0] vscale_step,
  input  wire        vfilter_enable,
  input  wire [9:0]  hcrop_start,
  input  wire [9:0]  hcrop_len,
  input  wire [9:0]  vcrop_start,
  input  wire [9:0]  vcrop_len,
  input  wire [5:0]  decim_period,
  input  wire        decim_frames,
  input  wire        wide_mode,
  input  wire        embed_codes,
  output reg         double_rate_pixel_clock,
  output reg         single_rate_pixel_clock,
  output reg  [7:0]  pix_lo,
  output reg  [7:0]  pix_hi,
  output reg         pix_valid,
  output reg         pix_active,
  output reg         line_start_marker,
  output reg         field_start_marker
);

  function [15:0] lim_step;
    input [15:0] s;
    begin
      if (s < `STEP_UNITY)
        lim_step = `STEP_UNITY;
      else if (s > `STEP_MAX)
        lim_step = `STEP_MAX;
      else
        lim_step = s;
    end
  endfunction

  function [7:0] clamp;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (v < lo)
        clamp = lo;
      else if (v > hi)
        clamp = hi;
      else
        clamp = v;
    end
  endfunction

  function in_win;
    input [9:0] pos;
    input [9:0] start;
    input [9:0] len;
    begin
      in_win = ({1'b0, pos} >= {1'b0, start}) &&
               ({1'b0, pos} < ({1'b0, start} + {1'b0, len}));
    end
  endfunction

  // Input selection
  reg [15:0] sel_src;
  always @* begin
    case (input_select)
      2'b00:   sel_src = src0;
      2'b01:   sel_src = src1;
      2'b10:   sel_src = src2;
      2'b11:   sel_src = src3;
      default: sel_src = src0;
    endcase
  end
  wire [7:0] cur_y = sel_src[7:0];
  wire [7:0] cur_c = svideo_mode ? svideo_chroma : sel_src[15:8];

  wire take = in_valid && src_ready;
  wire [15:0] step_h = lim_step(hscale_step);
  wire [15:0] step_v = lim_step(vscale_step);

  reg [7:0]  t0;
  reg [7:0]  t1;
  reg [7:0]  t2;
  reg [7:0]  t3;
  reg [7:0]  t4;
  reg [15:0] hacc;
  reg [15:0] vacc;
  reg [9:0]  hpos;
  reg [9:0]  vpos;
  reg [5:0]  ocol;
  reg [5:0]  fcnt;
  reg        line_keep;
  reg        field_keep;
  reg        pend_line;
  reg        pend_field;
  reg        prev_active;
  reg [7:0]  cb_hold;
  reg [7:0]  cr_hold;
  reg        st_valid;
  reg [`W_WIDTH-1:0] st_word;
  reg [7:0]  ls0 [0:`LS_COLS-1];
  reg [7:0]  ls1 [0:`LS_COLS-1];
  reg [7:0]  ls2 [0:`LS_COLS-1];
  reg [7:0]  ls3 [0:`LS_COLS-1];

  // Horizontal six-tap filter, taps 1 2 5 5 2 1 over 16
  wire [11:0] hsum = {4'h0, cur_y} + {3'h0, t0, 1'b0} +
                     ({4'h0, t1} + {2'h0, t1, 2'b00}) +
                     ({4'h0, t2} + {2'h0, t2, 2'b00}) +
                     {3'h0, t3, 1'b0} + {4'h0, t4};
  wire [7:0] hy = hsum[11:4];

  // Horizontal ratio
  wire [15:0] hbase = in_line_start ? `RST_ACC : hacc;
  wire [15:0] hnext = hbase + `STEP_UNITY;
  wire        emit  = hnext >= step_h;

  // Vertical ratio, evaluated once per line
  wire [15:0] vbase = in_field_start ? `RST_ACC : vacc;
  wire [15:0] vnext = vbase + `STEP_UNITY;
  wire        vkeep = vnext >= step_v;
  wire        keep_now = in_line_start ? vkeep : line_keep;

  // Field and frame dropping
  wire        new_unit = in_field_start && (!decim_frames || !in_field);
  wire        last_unit = (decim_period != `RST_FCNT) &&
                          (fcnt == decim_period - 6'h01);
  wire        fkeep_new = !(new_unit && last_unit);
  wire        fkeep_now = in_field_start ?
                          (new_unit ? fkeep_new : field_keep) : field_keep;

  // Vertical five-tap filter, taps 1 4 6 4 1 over 16
  wire [5:0]  col_now = in_line_start ? `RST_COL : ocol;
  wire [7:0]  v0 = ls0[col_now];
  wire [7:0]  v1 = ls1[col_now];
  wire [7:0]  v2 = ls2[col_now];
  wire [7:0]  v3 = ls3[col_now];
  wire [11:0] vsum = {4'h0, hy} + {2'h0, v0, 2'b00} +
                     ({3'h0, v1, 1'b0} + {2'h0, v1, 2'b00}) +
                     {2'h0, v2, 2'b00} + {4'h0, v3};
  wire [7:0]  out_y = vfilter_enable ? vsum[11:4] : hy;

  // Cropping
  wire [9:0] hp_now = in_line_start ? `RST_POS : hpos;
  wire [9:0] vp_now = in_field_start ? `RST_POS :
                      (in_line_start ? vpos + 10'h001 : vpos);
  wire active = keep_now && fkeep_now &&
                in_win(hp_now, hcrop_start, hcrop_len) &&
                in_win(vp_now, vcrop_start, vcrop_len);

  wire       lflag = in_line_start || pend_line;
  wire       fflag = in_field_start || pend_field;
  wire [7:0] chroma_now = col_now[0] ? cr_hold : cb_hold;

  reg [7:0] w_y;
  reg [7:0] w_c;
  always @* begin
    w_y = `BLANK_Y;
    w_c = `BLANK_C;
    if (active) begin
      w_y = clamp(out_y, `LUMA_MIN, `LUMA_MAX);
      w_c = clamp(chroma_now, `CHROMA_MIN, `CHROMA_MAX);
    end
    if (embed_codes && (lflag || fflag || (active && !prev_active))) begin
      w_y = `CODE_Y_BASE | {5'h00, active, lflag, fflag};
      w_c = `CODE_C;
    end
  end

  wire f_in_ready;
  wire f_out_valid;
  wire f_out_ready;
  wire [`W_WIDTH-1:0] f_out_data;
  wire [`FIFO_AW:0] f_level;

  pixel_fifo #(
    .W  (`W_WIDTH),
    .D  (`FIFO_DEPTH),
    .AW (`FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (st_valid),
    .in_ready  (f_in_ready),
    .in_data   (st_word),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  integer k;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      src_ready   <= 1'b0;
      t0          <= `RST_BYTE;
      t1          <= `RST_BYTE;
      t2          <= `RST_BYTE;
      t3          <= `RST_BYTE;
      t4          <= `RST_BYTE;
      hacc        <= `RST_ACC;
      vacc        <= `RST_ACC;
      hpos        <= `RST_POS;
      vpos        <= `RST_POS;
      ocol        <= `RST_COL;
      fcnt        <= `RST_FCNT;
      line_keep   <= 1'b1;
      field_keep  <= 1'b1;
      pend_line   <= 1'b0;
      pend_field  <= 1'b0;
      prev_active <= 1'b0;
      cb_hold     <= `BLANK_C;
      cr_hold     <= `BLANK_C;
      st_valid    <= 1'b0;
      st_word     <= {`W_WIDTH{1'b0}};
      for (k = 0; k < `LS_COLS; k = k + 1) begin
        ls0[k] <= `RST_BYTE;
        ls1[k] <= `RST_BYTE;
        ls2[k] <= `RST_BYTE;
        ls3[k] <= `RST_BYTE;
      end
    end else begin
      // Leaves room for words already in flight
      src_ready <= (f_level <= `FIFO_ROOM);
      if (st_valid && f_in_ready)
        st_valid <= 1'b0;
      if (take) begin
        t0 <= cur_y;
        t1 <= t0;
        t2 <= t1;
        t3 <= t2;
        t4 <= t3;
        hpos <= hp_now + 10'h001;
        vpos <= vp_now;
        if (hp_now[0])
          cr_hold <= cur_c;
        else
          cb_hold <= cur_c;
        if (in_line_start) begin
          vacc      <= vkeep ? vnext - step_v : vnext;
          line_keep <= vkeep;
        end
        if (new_unit) begin
          fcnt       <= last_unit ? `RST_FCNT : fcnt + 6'h01;
          field_keep <= fkeep_new;
        end
        hacc <= emit ? hnext - step_h : hnext;
        if (emit) begin
          ls0[col_now] <= hy;
          ls1[col_now] <= v0;
          ls2[col_now] <= v1;
          ls3[col_now] <= v2;
          ocol        <= col_now + 6'h01;
          pend_line   <= 1'b0;
          pend_field  <= 1'b0;
          prev_active <= active;
          st_valid    <= 1'b1;
          st_word     <= {active, lflag, fflag, w_c, w_y};
        end else begin
          ocol <= col_now;
          if (in_line_start)
            pend_line <= 1'b1;
          if (in_field_start)
            pend_field <= 1'b1;
        end
      end
    end
  end

  // Pixel clock side, reference sampled by sys_clk
  reg ntsc_s1;
  reg ntsc_s2;
  reg pal_s1;
  reg pal_s2;
  reg ref_q;
  reg [`W_WIDTH-1:0] held;
  wire ref_lvl = pal_select ? pal_s2 : ntsc_s2;
  wire ref_rise = ref_lvl && !ref_q;
  wire load = ref_rise && !single_rate_pixel_clock;
  assign f_out_ready = load;
  wire [`W_WIDTH-1:0] blank_word = {3'b000, `BLANK_C, `BLANK_Y};
  wire [`W_WIDTH-1:0] next_held = f_out_valid ? f_out_data : blank_word;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ntsc_s1 <= 1'b0;
      ntsc_s2 <= 1'b0;
      pal_s1  <= 1'b0;
      pal_s2  <= 1'b0;
      ref_q   <= 1'b0;
      held    <= blank_word;
      double_rate_pixel_clock <= 1'b0;
      single_rate_pixel_clock <= 1'b0;
      pix_lo             <= `BLANK_Y;
      pix_hi             <= `RST_BYTE;
      pix_valid          <= 1'b0;
      pix_active         <= 1'b0;
      line_start_marker  <= 1'b0;
      field_start_marker <= 1'b0;
    end else begin
      ntsc_s1 <= ntsc_xtal;
      ntsc_s2 <= ntsc_s1;
      pal_s1  <= pal_xtal;
      pal_s2  <= pal_s1;
      ref_q   <= ref_lvl;
      double_rate_pixel_clock <= ref_lvl;
      if (ref_rise)
        single_rate_pixel_clock <= !single_rate_pixel_clock;
      if (load) begin
        held               <= next_held;
        pix_valid          <= f_out_valid;
        pix_active         <= next_held[`W_ACTIVE];
        line_start_marker  <= next_held[`W_LSTART];
        field_start_marker <= next_held[`W_FSTART];
        if (wide_mode) begin
          pix_lo <= next_held[`W_Y_LSB +: 8];
          pix_hi <= next_held[`W_C_LSB +: 8];
        end else begin
          pix_lo <= next_held[`W_C_LSB +: 8];
          pix_hi <= `RST_BYTE;
        end
      end else if (ref_rise && !wide_mode) begin
        pix_lo <= held[`W_Y_LSB +: 8];
      end
    end
  end

endmodule
`default_nettype wire

/* File: common/pixel_port_defs.vh */
`ifndef PIXEL_PORT_DEFS_VH
`define PIXEL_PORT_DEFS_VH

// Scale step format 5.11, 1.0 = UNITY
`define STEP_UNITY 16'h0800
`define STEP_MAX 16'h8000

// Stream values
`define BLANK_Y 8'h10
`define BLANK_C 8'h80
`define LUMA_MIN 8'h10
`define LUMA_MAX 8'hEB
`define CHROMA_MIN 8'h10
`define CHROMA_MAX 8'hF0
`define CODE_C 8'hFF
`define CODE_Y_BASE 8'h00

// Word layout in the pixel buffer
`define W_Y_LSB 0
`define W_C_LSB 8
`define W_FSTART 16
`define W_LSTART 17
`define W_ACTIVE 18
`define W_WIDTH 19

// Buffer and line store
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define FIFO_ROOM 4'h5
`define LS_COLS 64

// Reset values
`define RST_BYTE 8'h00
`define RST_ACC 16'h0000
`define RST_POS 10'h000
`define RST_COL 6'h00
`define RST_FCNT 6'h00

`endif

/* File: bench/pixel_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pixel_port_defs.vh"
module pixel_port_chk (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       ntsc_xtal,
  input wire logic       pal_xtal,
  input wire logic       pal_select,
  input wire logic       wide_mode,
  input wire logic       embed_codes,
  input wire logic       src_ready,
  input wire logic       double_rate_pixel_clock,
  input wire logic       single_rate_pixel_clock,
  input wire logic [7:0] pix_lo,
  input wire logic [7:0] pix_hi,
  input wire logic       pix_valid,
  input wire logic       pix_active,
  input wire logic       line_start_marker,
  input wire logic       field_start_marker
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence ref_rise;
    $rose(double_rate_pixel_clock) ##0 $stable(pal_select);
  endsequence
  sequence half_step;
    $changed(single_rate_pixel_clock);
  endsequence
  chk_half_rate: assert property (half_step |-> ##[0:2] double_rate_pixel_clock)
    else $error("single rate moved outside a double rate high");
  chk_half_gap: assert property (half_step |=> $stable(single_rate_pixel_clock)[*8])
    else $error("single rate toggled too soon");
  chk_ref_select: assert property (ref_rise |-> (pal_select ? pal_xtal : ntsc_xtal))
    else $error("output clock follows the wrong reference");
  chk_reset_state: assert property ($fell(sys_rst) |-> !single_rate_pixel_clock
    && !double_rate_pixel_clock && pix_lo == `BLANK_Y && pix_hi == 8'h00 && !pix_valid
    && !line_start_marker && !field_start_marker && !src_ready)
    else $error("outputs not at rest after reset");
  chk_ready_start: assert property ($fell(sys_rst) |-> ##[0:3] src_ready)
    else $error("source never made ready");
  chk_byte_hi: assert property ((!wide_mode)[*4] |-> pix_hi == 8'h00)
    else $error("upper lane busy in byte mode");
  chk_wide_pace: assert property (wide_mode && $changed(pix_lo) |-> ##[0:1] single_rate_pixel_clock)
    else $error("wide pixel not paced by single rate");
  chk_line_valid: assert property (line_start_marker |-> pix_valid)
    else $error("line start on filler pixel");
  chk_code_form: assert property (wide_mode && embed_codes && pix_valid && pix_hi == `CODE_C
    |-> pix_lo == {5'b0, pix_active, line_start_marker, field_start_marker})
    else $error("control code body wrong");
  chk_marker_code: assert property (wide_mode && embed_codes && line_start_marker
    |-> pix_hi == `CODE_C)
    else $error("line start not coded");
  chk_legal_range: assert property (wide_mode && pix_valid && pix_hi != `CODE_C
    |-> pix_lo inside {[`LUMA_MIN:`LUMA_MAX]} && pix_hi inside {[`CHROMA_MIN:`CHROMA_MAX]})
    else $error("sample outside legal range");
endmodule
bind video_pixel_output_port pixel_port_chk u_chk (.sys_clk, .sys_rst, .ntsc_xtal, .pal_xtal,
  .pal_select, .wide_mode, .embed_codes, .src_ready, .double_rate_pixel_clock,
  .single_rate_pixel_clock, .pix_lo, .pix_hi, .pix_valid, .pix_active, .line_start_marker,
  .field_start_marker);
`default_nettype wire

/* File: bench/pixel_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module pixel_sink (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       wide_mode,
  input wire logic       single_rate_pixel_clock,
  input wire logic [7:0] pix_lo,
  input wire logic [7:0] pix_hi,
  input wire logic       pix_valid,
  input wire logic       pix_active,
  input wire logic       line_start_marker,
  input wire logic       field_start_marker
);
  logic [18:0] cap[$];
  logic        sr_d = 1'b0;
  logic [1:0]  dly = 2'b00;
  logic [7:0]  chroma = 8'h00;
  wire  [2:0]  flags = {field_start_marker, line_start_marker, pix_active};
  // Samples three cycles after each single rate edge
  always @(posedge sys_clk) begin
    sr_d <= single_rate_pixel_clock;
    dly <= {dly[0], !sys_rst && (single_rate_pixel_clock != sr_d)};
    if (dly[1] && wide_mode && single_rate_pixel_clock && pix_valid)
      cap.push_back({flags, pix_hi, pix_lo});
    if (dly[1] && !wide_mode && single_rate_pixel_clock)
      chroma <= pix_lo;
    if (dly[1] && !wide_mode && !single_rate_pixel_clock && pix_valid)
      cap.push_back({flags, chroma, pix_lo});
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, ntsc_xtal = 1'b0, pal_xtal = 1'b0;
  logic        pal_select = 1'b0, svideo_mode = 1'b0, wide_mode = 1'b1, embed_codes = 1'b0;
  logic        in_valid = 1'b0, in_line_start = 1'b0, in_field_start = 1'b0, in_field = 1'b0;
  logic        vfilter_enable = 1'b0, decim_frames = 1'b0;
  logic [1:0]  input_select = 2'h2;
  logic [5:0]  decim_period = 6'h00;
  logic [7:0]  svideo_chroma = 8'h66;
  logic [9:0]  hcrop_start = 10'h000, hcrop_len = 10'h3FF;
  logic [9:0]  vcrop_start = 10'h000, vcrop_len = 10'h3FF;
  logic [15:0] sample = 16'h7050, hscale_step = 16'h0800, vscale_step = 16'h0800;
  wire         src_ready, dclk, sclk, pix_valid, pix_active, lsm, fsm;
  wire  [7:0]  pix_lo, pix_hi;
  int          fails = 0, compares = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  always #80 ntsc_xtal = ~ntsc_xtal;
  initial #43 forever #80 pal_xtal = ~pal_xtal;
  video_pixel_output_port u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ntsc_xtal(ntsc_xtal),
    .pal_xtal(pal_xtal), .pal_select(pal_select), .src0(16'h8020), .src1(16'h9030),
    .src2(sample), .src3(16'h8020), .svideo_chroma(svideo_chroma), .svideo_mode(svideo_mode),
    .input_select(input_select), .in_valid(in_valid), .in_line_start(in_line_start),
    .in_field_start(in_field_start), .in_field(in_field), .src_ready(src_ready),
    .hscale_step(hscale_step), .vscale_step(vscale_step), .vfilter_enable(vfilter_enable),
    .hcrop_start(hcrop_start), .hcrop_len(hcrop_len), .vcrop_start(vcrop_start),
    .vcrop_len(vcrop_len), .decim_period(decim_period), .decim_frames(decim_frames),
    .wide_mode(wide_mode), .embed_codes(embed_codes), .double_rate_pixel_clock(dclk),
    .single_rate_pixel_clock(sclk), .pix_lo(pix_lo), .pix_hi(pix_hi), .pix_valid(pix_valid),
    .pix_active(pix_active), .line_start_marker(lsm), .field_start_marker(fsm));
  pixel_sink u_sink (.sys_clk(sys_clk), .sys_rst(sys_rst), .wide_mode(wide_mode),
    .single_rate_pixel_clock(sclk), .pix_lo(pix_lo), .pix_hi(pix_hi), .pix_valid(pix_valid),
    .pix_active(pix_active), .line_start_marker(lsm), .field_start_marker(fsm));
  task automatic check(input logic [18:0] got, input logic [18:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    u_sink.cap.delete();
  endtask
  function automatic int n_active();
    int a = 0;
    for (int i = 0; i < u_sink.cap.size(); i++)
      a += u_sink.cap[i][16];
    return a;
  endfunction
  task automatic send(input int n, input logic f, input logic fs = 1'b1);
    logic r;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_line_start <= (i == 0);
      in_field_start <= fs && (i == 0);
      in_field <= f;
      do begin
        @(negedge sys_clk);
        r = src_ready;
        @(posedge sys_clk);
      end while (r !== 1'b1);
    end
    in_valid <= 1'b0;
  endtask
  task automatic drain(input int n);
    int w = 0;
    while (u_sink.cap.size() < n && w < 1500) begin
      @(posedge sys_clk);
      w++;
    end
    repeat (80) @(posedge sys_clk);
  endtask
  task automatic line16(input logic [18:0] exp);
    send(16, 1'b0);
    drain(16);
    check(19'(u_sink.cap.size()), 19'd16);
    check(u_sink.cap[8], exp);
    check(19'(u_sink.cap[0][18:16]), 19'h7);
  endtask
  task automatic t_wide;
    rst();
    line16(19'h17050);
  endtask
  task automatic t_byte;
    @(posedge sys_clk);
    wide_mode <= 1'b0;
    pal_select <= 1'b1;
    svideo_mode <= 1'b1;
    rst();
    line16(19'h16650);
  endtask
  task automatic t_crop;
    @(posedge sys_clk);
    wide_mode <= 1'b1;
    svideo_mode <= 1'b0;
    embed_codes <= 1'b1;
    hcrop_start <= 10'h004;
    hcrop_len <= 10'h004;
    rst();
    send(16, 1'b0);
    drain(16);
    check(u_sink.cap[0], 19'h6FF03);
    check(u_sink.cap[4], 19'h1FF04);
    check(19'(u_sink.cap[2][16]), 19'h0);
    check(19'(u_sink.cap[5][16]), 19'h1);
    check(19'(u_sink.cap[10][16]), 19'h0);
  endtask
  task automatic t_scale;
    logic [15:0] st[3] = '{16'h1000, 16'h8000, 16'hFFFF};
    int ex[3] = '{16, 2, 2};
    foreach (st[k]) begin
      @(posedge sys_clk);
      embed_codes <= 1'b0;
      hcrop_start <= 10'h000;
      hcrop_len <= 10'h3FF;
      hscale_step <= st[k];
      rst();
      send(32, 1'b0);
      drain(ex[k]);
      check(19'(u_sink.cap.size()), 19'(ex[k]));
    end
  endtask
  task automatic t_decim;
    logic [3:0] keep[2] = '{4'b0101, 4'b0011};
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      hscale_step <= 16'h0800;
      decim_period <= 6'h02;
      decim_frames <= m[0];
      rst();
      for (int f = 0; f < 4; f++) begin
        send(4, f[0]);
        drain(4);
        check(19'(n_active()), keep[m][f] ? 19'd4 : 19'd0);
        u_sink.cap.delete();
      end
    end
  endtask
  task automatic t_select;
    @(posedge sys_clk);
    decim_period <= 6'h00;
    input_select <= 2'h1;
    rst();
    line16(19'h19030);
  endtask
  task automatic t_vdrop;
    @(posedge sys_clk);
    input_select <= 2'h2;
    vscale_step <= 16'h1000;
    rst();
    for (int l = 0; l < 4; l++) begin
      send(4, 1'b0, l == 0);
      drain(4);
      check(19'(n_active()), l[0] ? 19'd4 : 19'd0);
      u_sink.cap.delete();
    end
  endtask
  task automatic t_vfilt;
    @(posedge sys_clk);
    vscale_step <= 16'h0800;
    vfilter_enable <= 1'b1;
    rst();
    send(8, 1'b0);
    drain(8);
    u_sink.cap.delete();
    send(8, 1'b0, 1'b0);
    drain(8);
    check(u_sink.cap[6], 19'h17019);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  initial begin
    t_wide();
    t_byte();
    t_crop();
    t_scale();
    t_decim();
    t_select();
    t_vdrop();
    t_vfilt();
    results();
  end
endmodule
`default_nettype wire
